// File: design/apm_defines.svh
`ifndef APM_DEFINES_SVH
`define APM_DEFINES_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL        8'h00
`define OFS_DOZE        8'h04
`define OFS_INT_STATUS  8'h18
`define OFS_INT_CLEAR   8'h1C
`define OFS_INT_ENABLE  8'h20
`define OFS_PLANE       8'h24
`define OFS_SEQ         8'h28
`define OFS_MOD         8'h2C
`define TMR_STRIDE      4

// ----------------------------------------
// Field positions and widths
// ----------------------------------------
`define CTRL_EN         0
`define CTRL_PWR_LO     1
`define ADDR_W          8
`define TMR_W           16
`define PLANE_W         4
`define DUTY_W          4
`define MOD_W           16
`define NUM_ACT         3
`define ACT_SYS         0
`define ACT_HK          1
`define ACT_PERIPH      2
`define PWR_W           2
`define SEQ_W           2
`define SEQ_HK_BIT      2
`define SEQ_STOP_BIT    3
`define SEQ_ACT_LO      4

// ----------------------------------------
// Timer and status indices
// ----------------------------------------
`define NUM_TMR         5
`define TMR_DOZE        0
`define TMR_STBY        1
`define TMR_CORE_SUSPEND_REQUEST_N        2
`define TMR_HK          3
`define TMR_PERIPH      4
`define ST_WAKE         5
`define ST_W            6

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define PERIOD_RST      16'h0100
`define MOD_RST         16'h0000
`define PLANE_RST       4'h0
`define CLK_NS          10
`define TICK_NS         1000
`define TICK_CYCLES     ((`TICK_NS + `CLK_NS - 1) / `CLK_NS)
`define TICK_CNT_W      7

`endif

// File: design/apm_pkg.sv
package apm_pkg;

    typedef enum logic [1:0] {
        PWR_ON      = 2'b00,
        PWR_DOZE    = 2'b01,
        PWR_STANDBY = 2'b10,
        PWR_SUSPEND = 2'b11
    } pwr_state_t;

    typedef enum logic [1:0] {
        SEQ_RUN     = 2'b00,
        SEQ_REQ     = 2'b01,
        SEQ_STOP    = 2'b10,
        SEQ_RESUME  = 2'b11
    } seq_state_t;

endpackage

// File: design/timer_if.sv
`timescale 1ns/10ps
`include "apm_defines.svh"

interface timer_if;
    logic              tick;
    logic              run;
    logic              reload;
    logic [`TMR_W-1:0] period;
    logic              expire;

    modport ctl (output tick, output run, output reload, output period, input expire);
    modport tmr (input tick, input run, input reload, input period, output expire);
endinterface

// File: design/inactivity_timer.sv
`timescale 1ns/10ps
`include "apm_defines.svh"

module inactivity_timer
    import apm_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    timer_if.tmr     t
);

    logic [`TMR_W-1:0] cnt_q;
    logic              expire_q;

    // ----------------------------------------
    // Down counter
    // ----------------------------------------
    // reload on activity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= '0;
        end else if (!t.run || t.reload) begin
            cnt_q <= t.period;
        end else if (t.tick && cnt_q != '0) begin
            cnt_q <= cnt_q - `TMR_W'(1);
        end
    end

    // Single pulse; counter parks at zero until next reload
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expire_q <= 1'b0;
        end else begin
            expire_q <= t.run && !t.reload && t.tick && cnt_q == `TMR_W'(1);
        end
    end

    assign t.expire = expire_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_reload_period: assert property (@(posedge pclk) disable iff (!presetn)
        t.run && t.reload |=> cnt_q == $past(t.period))
        else $error("timer not reloaded to period");

    chk_expire_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(expire_q) |-> $past(cnt_q) == `TMR_W'(1) && $past(t.tick) && cnt_q == '0)
        else $error("timer expired without reaching zero");

endmodule

// File: design/activity_power_manager.sv
`timescale 1ns/10ps
`include "apm_defines.svh"

module activity_power_manager
    import apm_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [`ADDR_W-1:0]   paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [`NUM_ACT-1:0]  activity_in,
    input  wire logic                 core_suspend_ack,
    input  wire logic                 mgmt_software_mode,
    output logic                      core_suspend_request_n,
    output logic                      core_clock_stop,
    output logic                      mgmt_interrupt,
    output logic      [`PLANE_W-1:0]  power_plane_en
);

    function automatic logic is_reg(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
        is_reg = (a == ofs);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   en_q;
    pwr_state_t             pwr_q;
    logic [`TMR_W-1:0]      period_q [`NUM_TMR];
    logic [`ST_W-1:0]       st_q;
    logic [`ST_W-1:0]       ien_q;
    logic [`PLANE_W-1:0]    plane_q;
    logic [`MOD_W-1:0]      mod_q;
    seq_state_t             seq_q;
    seq_state_t             seq_d;
    logic [`TICK_CNT_W-1:0] tick_cnt_q;
    logic                   tick_q;
    logic [`DUTY_W-1:0]     mod_cnt_q;
    logic                   hk_busy_q;
    logic [`NUM_ACT-1:0]    s1_q;
    logic [`NUM_ACT-1:0]    s2_q;
    logic [`NUM_ACT-1:0]    s3_q;
    logic [`NUM_ACT-1:0]    act_q;
    logic [`NUM_ACT-1:0]    act_prev_q;
    logic                   req_n_q;
    logic                   clk_stop_q;
    logic                   irq_q;
    logic [`PLANE_W-1:0]    plane_en_q;

    logic                   acc;
    logic                   wr_go;
    logic [31:0]            rd_data;
    logic                   rd_err;
    logic [`NUM_ACT-1:0]    act_rise;
    logic [`NUM_TMR-1:0]    exp_vec;
    logic [`NUM_TMR-1:0]    reload_vec;
    logic [`ST_W-1:0]       set_vec;
    logic [`ST_W-1:0]       clr_vec;
    logic [`ST_W-1:0]       set_clr;
    logic                   low_pwr_hk;
    logic                   wake_resume;
    logic [`DUTY_W-1:0]     duty_cur;
    logic                   mod_on;

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    // One wait state: ready and data are both registered
    assign acc   = psel && penable && !pready_q;
    assign wr_go = psel && penable && pwrite && pready_q;

    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        if (is_reg(paddr, `OFS_CTRL)) begin
            rd_data[`CTRL_EN] = en_q;
            rd_data[`CTRL_PWR_LO +: `PWR_W] = pwr_q;
        end else if (is_reg(paddr, `OFS_INT_STATUS)) begin
            rd_data[`ST_W-1:0] = st_q;
        end else if (is_reg(paddr, `OFS_INT_CLEAR)) begin
            rd_data = '0;
        end else if (is_reg(paddr, `OFS_INT_ENABLE)) begin
            rd_data[`ST_W-1:0] = ien_q;
        end else if (is_reg(paddr, `OFS_PLANE)) begin
            rd_data[`PLANE_W-1:0] = plane_q;
        end else if (is_reg(paddr, `OFS_SEQ)) begin
            rd_data[`SEQ_W-1:0]              = seq_q;
            rd_data[`SEQ_HK_BIT]             = hk_busy_q;
            rd_data[`SEQ_STOP_BIT]           = clk_stop_q;
            rd_data[`SEQ_ACT_LO +: `NUM_ACT] = act_q;
        end else if (is_reg(paddr, `OFS_MOD)) begin
            rd_data[`MOD_W-1:0] = mod_q;
        end else begin
            rd_err = 1'b1;
            for (int i = 0; i < `NUM_TMR; i++) begin
                if (is_reg(paddr, `ADDR_W'(`OFS_DOZE + `TMR_STRIDE * i))) begin
                    rd_data[`TMR_W-1:0] = period_q[i];
                    rd_err = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc;
            prdata_q  <= (acc && !pwrite) ? rd_data : '0;
            pslverr_q <= acc && rd_err;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    assign wake_resume = (seq_q == SEQ_STOP) && st_q[`ST_WAKE] && ien_q[`ST_WAKE];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q  <= 1'b0;
            pwr_q <= PWR_ON;
        end else if (wake_resume) begin
            pwr_q <= PWR_ON;
        end else if (wr_go && is_reg(paddr, `OFS_CTRL)) begin
            en_q  <= pwdata[`CTRL_EN];
            pwr_q <= pwr_state_t'(pwdata[`CTRL_PWR_LO +: `PWR_W]);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_q   <= '0;
            plane_q <= `PLANE_RST;
            mod_q   <= `MOD_RST;
        end else if (wr_go) begin
            if (is_reg(paddr, `OFS_INT_ENABLE)) begin
                ien_q <= pwdata[`ST_W-1:0];
            end
            if (is_reg(paddr, `OFS_PLANE)) begin
                plane_q <= pwdata[`PLANE_W-1:0];
            end
            if (is_reg(paddr, `OFS_MOD)) begin
                mod_q <= pwdata[`MOD_W-1:0];
            end
        end
    end

    // ----------------------------------------
    // Activity input synchronisers
    // ----------------------------------------
    // Filtered level moves only when stages two and three agree
    generate
        for (genvar a = 0; a < `NUM_ACT; a++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    s1_q[a]       <= 1'b0;
                    s2_q[a]       <= 1'b0;
                    s3_q[a]       <= 1'b0;
                    act_q[a]      <= 1'b0;
                    act_prev_q[a] <= 1'b0;
                end else begin
                    s1_q[a]       <= activity_in[a];
                    s2_q[a]       <= s1_q[a];
                    s3_q[a]       <= s2_q[a];
                    act_q[a]      <= (s2_q[a] == s3_q[a]) ? s3_q[a] : act_q[a];
                    act_prev_q[a] <= act_q[a];
                end
            end
        end
    endgenerate

    assign act_rise = act_q & ~act_prev_q;

    // ----------------------------------------
    // Tick divider
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q == `TICK_CNT_W'(`TICK_CYCLES - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + `TICK_CNT_W'(1);
            tick_q     <= 1'b0;
        end
    end

    // ----------------------------------------
    // Inactivity timers
    // ----------------------------------------
    // reload per activity class
    always_comb begin
        reload_vec = '0;
        reload_vec[`TMR_DOZE]   = act_q[`ACT_SYS];
        reload_vec[`TMR_STBY]   = act_q[`ACT_SYS];
        reload_vec[`TMR_CORE_SUSPEND_REQUEST_N]   = act_q[`ACT_SYS];
        reload_vec[`TMR_HK]     = act_q[`ACT_HK];
        reload_vec[`TMR_PERIPH] = act_q[`ACT_PERIPH];
    end

    timer_if tif [`NUM_TMR] ();

    generate
        for (genvar i = 0; i < `NUM_TMR; i++) begin : g_tmr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    period_q[i] <= `PERIOD_RST;
                end else if (wr_go && is_reg(paddr, `ADDR_W'(`OFS_DOZE + `TMR_STRIDE * i))) begin
                    period_q[i] <= pwdata[`TMR_W-1:0];
                end
            end
            assign tif[i].tick   = tick_q;
            assign tif[i].run    = en_q;
            assign tif[i].reload = reload_vec[i];
            assign tif[i].period = period_q[i];
            assign exp_vec[i]    = tif[i].expire;
            inactivity_timer u_tmr (
                .pclk    (pclk),
                .presetn (presetn),
                .t       (tif[i])
            );
        end
    endgenerate

    // ----------------------------------------
    // Housekeeping burst tracking
    // ----------------------------------------
    assign low_pwr_hk = (pwr_q == PWR_DOZE) || (pwr_q == PWR_STANDBY);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hk_busy_q <= 1'b0;
        end else if (act_q[`ACT_HK] && low_pwr_hk) begin
            hk_busy_q <= 1'b1;
        end else if (exp_vec[`TMR_HK] || !low_pwr_hk) begin
            hk_busy_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Interrupt status
    // ----------------------------------------
    always_comb begin
        set_vec = '0;
        set_vec[`TMR_PERIPH:0] = exp_vec;
        set_vec[`TMR_HK]       = exp_vec[`TMR_HK] && hk_busy_q;
        set_vec[`ST_WAKE]      = act_rise[`ACT_SYS] && (pwr_q != PWR_ON);
    end

    assign clr_vec = (wr_go && is_reg(paddr, `OFS_INT_CLEAR)) ? pwdata[`ST_W-1:0] : '0;
    assign set_clr = set_vec & clr_vec;

    // Set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= '0;
            irq_q <= 1'b0;
        end else begin
            st_q  <= (st_q & ~clr_vec) | set_vec;
            irq_q <= |(st_q & ien_q);
        end
    end

    // ----------------------------------------
    // Suspend sequencer
    // ----------------------------------------
    always_comb begin
        seq_d = seq_q;
        case (seq_q)
            SEQ_RUN: begin
                if (pwr_q == PWR_SUSPEND) begin
                    seq_d = SEQ_REQ;
                end
            end
            SEQ_REQ: begin
                if (core_suspend_ack) begin
                    seq_d = SEQ_STOP;
                end else if (pwr_q != PWR_SUSPEND) begin
                    seq_d = SEQ_RUN;
                end
            end
            SEQ_STOP: begin
                if (pwr_q != PWR_SUSPEND || wake_resume) begin
                    seq_d = SEQ_RESUME;
                end
            end
            SEQ_RESUME: begin
                seq_d = SEQ_RUN;
            end
            default: begin
                seq_d = SEQ_RUN;
            end
        endcase
    end

    // Full speed while management code or a housekeeping burst runs
    assign duty_cur = mod_q[`DUTY_W * pwr_q +: `DUTY_W];
    assign mod_on   = (mod_cnt_q < duty_cur) && !mgmt_software_mode && !hk_busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_cnt_q <= '0;
        end else if (tick_q) begin
            mod_cnt_q <= mod_cnt_q + `DUTY_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_q      <= SEQ_RUN;
            req_n_q    <= 1'b1;
            clk_stop_q <= 1'b0;
        end else begin
            seq_q      <= seq_d;
            req_n_q    <= !((seq_d != SEQ_RUN) || mod_on);
            clk_stop_q <= (seq_d == SEQ_STOP);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            plane_en_q <= '1;
        end else begin
            plane_en_q <= (seq_d == SEQ_STOP) ? ~plane_q : '1;
        end
    end

    assign prdata                 = prdata_q;
    assign pready                 = pready_q;
    assign pslverr                = pslverr_q;
    assign core_suspend_request_n = req_n_q;
    assign core_clock_stop        = clk_stop_q;
    assign mgmt_interrupt         = irq_q;
    assign power_plane_en         = plane_en_q;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_restart;
        !core_suspend_request_n && !core_clock_stop ##1 seq_q == SEQ_RUN;
    endsequence

    chk_stop_after_ack: assert property (
        $rose(core_clock_stop) |-> !core_suspend_request_n && $past(core_suspend_ack))
        else $error("clock stopped without core acknowledge");

    chk_stop_holds: assert property (
        core_clock_stop && pwr_q == PWR_SUSPEND && !wake_resume |=> core_clock_stop)
        else $error("clock stop dropped while suspended");

    chk_resume_order: assert property (
        $fell(core_clock_stop) |-> s_restart)
        else $error("request released before clocks restarted");

    chk_expiry_irq: assert property (
        exp_vec[`TMR_DOZE] && ien_q[`TMR_DOZE] && !wr_go |-> ##2 mgmt_interrupt)
        else $error("doze expiry did not raise interrupt");

    chk_set_wins: assert property (
        |set_clr |=> |(st_q & $past(set_clr)))
        else $error("status event lost to clear");

    chk_wake_status: assert property (
        act_rise[`ACT_SYS] && pwr_q != PWR_ON |=> st_q[`ST_WAKE])
        else $error("activity in low power not flagged");

    chk_hk_busy: assert property (
        act_q[`ACT_HK] && low_pwr_hk |=> hk_busy_q && pwr_q == $past(pwr_q) || $past(wr_go))
        else $error("housekeeping burst not tracked");

    chk_plane_off: assert property (
        core_clock_stop && $stable(plane_q) |-> power_plane_en == ~plane_q)
        else $error("power planes not switched while stopped");

    chk_no_mod_zero: assert property (
        seq_q == SEQ_RUN && seq_d == SEQ_RUN && duty_cur == '0 |=> core_suspend_request_n)
        else $error("request asserted with zero duty");

endmodule

// File: sim/core_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Processor core seen from the power unit
// ----------------------------------------
module core_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       core_suspend_request_n,
    input  wire logic       core_clock_stop,
    input  wire logic [7:0] drain_cycles,
    output logic            core_suspend_ack
);
    logic [7:0] drain_q;

    // ack held through stop, dropped on release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drain_q          <= 8'h00;
            core_suspend_ack <= 1'b0;
        end else if (core_suspend_request_n) begin
            drain_q          <= 8'h00;
            core_suspend_ack <= 1'b0;
        end else if (drain_q < drain_cycles) begin
            drain_q <= drain_q + 8'h01;
        end else begin
            core_suspend_ack <= 1'b1;
        end
    end
endmodule

// File: sim/activity_power_manager_bench.sv
`timescale 1ns/10ps
`include "apm_defines.svh"

module activity_power_manager_bench;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        pready, pslverr, err;
    logic [2:0]  activity_in;
    logic        core_suspend_ack, mgmt_software_mode;
    logic        core_suspend_request_n, core_clock_stop, mgmt_interrupt;
    logic [3:0]  power_plane_en;
    logic [7:0]  drain;
    int          miscompares, comparisons, n;

    activity_power_manager uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .activity_in(activity_in), .core_suspend_ack(core_suspend_ack),
        .mgmt_software_mode(mgmt_software_mode), .core_suspend_request_n(core_suspend_request_n),
        .core_clock_stop(core_clock_stop), .mgmt_interrupt(mgmt_interrupt),
        .power_plane_en(power_plane_en));

    core_model core (.pclk(pclk), .presetn(presetn), .core_suspend_request_n(core_suspend_request_n),
        .core_clock_stop(core_clock_stop), .drain_cycles(drain), .core_suspend_ack(core_suspend_ack));

    always #5 pclk = ~pclk;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("miscompares=%0d comparisons=%0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        if (i == 20) begin
            chk(32'h0, 32'h1);
            stop_test();
        end
        rdata = prdata;
        err   = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask

    task automatic wait_stop(input logic lvl);
        int k;
        for (k = 0; k < 100 && core_clock_stop !== lvl; k++) @(posedge pclk);
        if (k == 100) begin
            chk(core_clock_stop, lvl);
            stop_test();
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk({core_suspend_request_n, core_clock_stop, mgmt_interrupt, power_plane_en}, 32'h4F);
        for (int k = 0; k < 5; k++) begin
            apb(0, 8'(`OFS_DOZE + k * `TMR_STRIDE), 32'h0);
            chk(rdata, 32'h100);
        end
        apb(1, `OFS_INT_STATUS, 32'h3F);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h0);
        apb(0, 8'h40, 32'h0);
        chk(err, 1'b1);
        chk(rdata, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_timers();
        apb(1, 8'h04, 32'h1);
        apb(1, 8'h08, 32'h3);
        apb(1, 8'h0C, 32'h5);
        apb(1, 8'h14, 32'h2);
        apb(1, `OFS_INT_ENABLE, 32'h3F);
        activity_in <= 3'b101;
        apb(1, `OFS_CTRL, 32'h1);
        idle(600);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h0);
        chk(mgmt_interrupt, 1'b0);
        activity_in <= 3'b000;
        idle(100);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h1);
        idle(450);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h17);
        chk(mgmt_interrupt, 1'b1);
        apb(1, `OFS_INT_ENABLE, 32'h0);
        idle(3);
        chk(mgmt_interrupt, 1'b0);
        apb(1, `OFS_INT_CLEAR, 32'h3F);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h0);
        $display("timer test done");
    endtask

    task automatic t_wake();
        apb(1, `OFS_CTRL, 32'h3);
        activity_in <= 3'b001;
        idle(20);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h20);
        activity_in <= 3'b000;
        apb(1, `OFS_CTRL, 32'h1);
        apb(1, `OFS_INT_CLEAR, 32'h3F);
        $display("wake test done");
    endtask

    task automatic t_suspend();
        drain <= 8'hC8;
        apb(1, `OFS_CTRL, 32'h7);
        apb(1, `OFS_CTRL, 32'h1);
        n = 0;
        repeat (250) @(posedge pclk) n += core_clock_stop;
        chk(n, 0);
        drain <= 8'h03;
        apb(1, `OFS_PLANE, 32'h5);
        apb(1, `OFS_CTRL, 32'h7);
        wait_stop(1'b1);
        chk({core_suspend_ack, core_suspend_request_n, power_plane_en}, 32'h2A);
        idle(50);
        chk(core_clock_stop, 1'b1);
        apb(1, `OFS_CTRL, 32'h1);
        @(posedge pclk);
        #1;
        chk({core_clock_stop, core_suspend_request_n, power_plane_en}, 32'h0F);
        @(posedge pclk);
        #1;
        chk(core_suspend_request_n, 1'b1);
        $display("suspend test done");
    endtask

    task automatic t_modulate();
        apb(1, `OFS_MOD, 32'hF);
        idle(20);
        n = 0;
        repeat (1600) @(posedge pclk) n += !core_suspend_request_n;
        chk(n, 1500);
        mgmt_software_mode <= 1'b1;
        idle(5);
        n = 0;
        repeat (1600) @(posedge pclk) n += !core_suspend_request_n;
        chk(n, 0);
        mgmt_software_mode <= 1'b0;
        $display("modulation test done");
    endtask

    // Burst in doze, then wake from suspend by activity
    task automatic t_hk();
        apb(1, 8'(`OFS_DOZE + `TMR_HK * `TMR_STRIDE), 32'h1);
        apb(1, `OFS_INT_CLEAR, 32'h3F);
        apb(1, `OFS_INT_ENABLE, 32'h8);
        apb(1, `OFS_CTRL, 32'h3);
        activity_in <= 3'b010;
        idle(10);
        apb(0, `OFS_SEQ, 32'h0);
        chk(rdata, 32'h24);
        activity_in <= 3'b000;
        idle(110);
        apb(0, `OFS_INT_STATUS, 32'h0);
        chk(rdata, 32'h8);
        chk(mgmt_interrupt, 1'b1);
        apb(0, `OFS_SEQ, 32'h0);
        chk(rdata, 32'h0);
        apb(0, `OFS_CTRL, 32'h0);
        chk(rdata, 32'h3);
        apb(1, `OFS_INT_CLEAR, 32'h3F);
        apb(1, `OFS_INT_ENABLE, 32'h20);
        apb(1, `OFS_CTRL, 32'h7);
        wait_stop(1'b1);
        activity_in <= 3'b001;
        wait_stop(1'b0);
        chk(mgmt_interrupt, 1'b1);
        apb(0, `OFS_CTRL, 32'h0);
        chk(rdata, 32'h1);
        activity_in <= 3'b000;
        $display("housekeeping test done");
    endtask

    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 8'h00; pwdata = 32'h0; activity_in = 3'b000;
        mgmt_software_mode = 0; drain = 8'h03;
        miscompares = 0; comparisons = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_timers();
        t_wake();
        t_suspend();
        t_modulate();
        t_hk();
        stop_test();
    end
endmodule
